// ===== rtl/fpeg_pkg.sv
// constants, types and state layout for the flash program/erase guard
// assumes one system clock, software strobes synchronous to it
// Notes on behaviour
// - high and low frequency bytes form a 16-bit kHz value timing program and erase.
// - outside the open level, one page opened per unlock; another page needs the full unlock again.
// - two option bits select one of three program memory protection levels.
// - open level ignores sector protection for program and erase.
// - open level does not confine programming to the selected page.
// - open level lets sector protection bits be written to one or zero.
// - open level completes unlock without the second page select write.
// - open level keeps page select writable while unlocked.
// - open level accepts and performs mass erase from the control port.
// - read guard option blocks debugger reads of user code.
// - 12KB space, lower 8KB user code, upper 4KB reserved for factory routines.
// - a user code call into the reserved region enters factory data routines.
// - code running from the reserved region may access the reserved region.
// - user code accesses to the reserved region are refused.
// - crystal option bit keeps oscillator running in reset when 0, stopped when 1.
package fpeg_pkg;

  // ****************************************************************
  // address space
  // ****************************************************************
  localparam int unsigned ADDR_W     = 14;
  localparam logic [13:0] USER_TOP   = 14'h2000;
  localparam logic [13:0] SPACE_TOP  = 14'h3000;
  localparam int unsigned PAGE_LSB   = 9;
  localparam int unsigned SECTOR_LSB = 10;

  // ****************************************************************
  // control port keys and commands (values arbitrary)
  // ****************************************************************
  localparam logic [7:0] KEY_FIRST      = 8'h73;
  localparam logic [7:0] KEY_SECOND     = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;

  // ****************************************************************
  // reset values and operation times
  // ****************************************************************
  localparam logic [15:0] FREQ_RESET       = 16'h0000;
  localparam logic [7:0]  PAGE_SEL_RESET   = 8'h00;
  localparam logic [7:0]  SECT_PROT_RESET  = 8'h00;
  localparam int unsigned PROG_TIME_US     = 40;
  localparam int unsigned PAGE_ERASE_US    = 10000;
  localparam int unsigned MASS_ERASE_US    = 200000;
  localparam int unsigned US_PER_MS        = 1000;

  typedef enum logic [2:0] {
    LK_LOCKED   = 3'b000,
    LK_KEY1     = 3'b001,
    LK_KEY2     = 3'b010,
    LK_PAGE1    = 3'b011,
    LK_UNLOCKED = 3'b100
  } fpeg_lock_type;

  typedef enum logic [1:0] {
    LVL_FULL  = 2'b00,
    LVL_GUARD = 2'b01,
    LVL_OPEN  = 2'b10
  } fpeg_level_type;

  typedef enum logic [1:0] {
    OP_PROG       = 2'b00,
    OP_PAGE_ERASE = 2'b01,
    OP_MASS_ERASE = 2'b10
  } fpeg_op_type;

  typedef struct packed {
    logic        prog;
    logic        pageErase;
    logic        massErase;
    logic [13:0] addr;
    logic [7:0]  data;
  } fpeg_array_cmd_type;

  typedef struct packed {
    fpeg_lock_type      lock;
    logic [15:0]        freq;
    logic [7:0]         pageSel;
    logic [7:0]         sectProt;
    fpeg_array_cmd_type cmd;
    logic               start;
    fpeg_op_type        op;
    logic               entry;
  } fpeg_state_type;

  typedef struct packed {
    logic        busy;
    logic [23:0] count;
  } fpeg_timer_type;

endpackage

// ===== rtl/fpeg_op_timer.sv
// operation timer: holds busy for a time scaled by the kHz frequency value
// assumes start is a one-cycle pulse issued only while not busy
`timescale 1ns/1ps
`default_nettype none
module fpeg_op_timer #(
  parameter int unsigned FREQ_W = 16
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                start,
  input  wire fpeg_pkg::fpeg_op_type op,
  input  wire logic [FREQ_W-1:0]   freqKhz,
  output logic                     busy,
  output logic                     done
);
  import fpeg_pkg::*;

  fpeg_timer_type q;
  fpeg_timer_type d;

  // cycles = kHz * us / 1000, rounded up, never below one
  function automatic logic [23:0] opCycles(input logic [FREQ_W-1:0] khz,
                                           input logic [17:0] us);
    logic [35:0] prod;
    logic [35:0] cyc;
    prod = 36'(khz) * 36'(us);
    cyc  = (prod + 36'(US_PER_MS - 1)) / 36'(US_PER_MS);
    if (cyc == 36'h0_0000_0000) begin
      cyc = 36'h0_0000_0001;
    end
    return cyc[23:0];
  endfunction

  always_comb begin
    d    = q;
    done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      case (op)
        OP_PROG:       d.count = opCycles(freqKhz, 18'(PROG_TIME_US));
        OP_PAGE_ERASE: d.count = opCycles(freqKhz, 18'(PAGE_ERASE_US));
        default:       d.count = opCycles(freqKhz, 18'(MASS_ERASE_US));
      endcase
    end else if (q.busy) begin
      if (q.count == 24'h00_0001) begin
        d.busy = 1'b0;
        done   = 1'b1;
      end
      d.count = q.count - 24'h00_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
endmodule
`default_nettype wire

// ===== rtl/fpeg_guard.sv
// flash program/erase guard: unlock sequence, protection levels,
// sector and page checks, reserved region and debugger read gating
// assumes software strobes are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`default_nettype none
module fpeg_guard #(
  parameter int unsigned FREQ_W = 16
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire logic                         writeGuardOpt,
  input  wire logic                         highSectorWriteGuardOpt,
  input  wire logic                         readGuardOpt,
  input  wire logic                         crystalOffInReset,
  input  wire logic                         freqHighWr,
  input  wire logic                         freqLowWr,
  input  wire logic                         ctrlWr,
  input  wire logic                         pageSelWr,
  input  wire logic                         sectProtWr,
  input  wire logic [7:0]                   wrData,
  input  wire logic                         progReq,
  input  wire logic [13:0]                  progAddr,
  input  wire logic [7:0]                   progData,
  input  wire logic [13:0]                  fetchAddr,
  input  wire logic                         accValid,
  input  wire logic [13:0]                  accAddr,
  input  wire logic                         callValid,
  input  wire logic [13:0]                  callTarget,
  input  wire logic [13:0]                  dbgRdAddr,
  output fpeg_pkg::fpeg_array_cmd_type      arrayCmd,
  output logic                              busy,
  output fpeg_pkg::fpeg_lock_type           lockState,
  output fpeg_pkg::fpeg_level_type          protLevel,
  output logic [FREQ_W-1:0]                 flashClockKhzValue,
  output logic [7:0]                        pageSel,
  output logic [7:0]                        sectProt,
  output logic                              accAllow,
  output logic                              factoryEntry,
  output logic                              dbgRdAllow,
  output logic                              crystalRunInReset
);
  import fpeg_pkg::*;

  fpeg_state_type q;
  fpeg_state_type d;
  fpeg_level_type level;
  logic           opDone;
  logic           progOk;
  logic           eraseOk;

  // ****************************************************************
  // address classification
  // ****************************************************************
  function automatic logic inReserved(input logic [13:0] a);
    return (a >= USER_TOP) && (a < SPACE_TOP);
  endfunction

  function automatic logic inUser(input logic [13:0] a);
    return a < USER_TOP;
  endfunction

  function automatic logic [7:0] pageOf(input logic [13:0] a);
    return {3'b000, a[13:PAGE_LSB]};
  endfunction

  // ****************************************************************
  // protection level from the two option bits
  // ****************************************************************
  always_comb begin
    if (!writeGuardOpt) begin
      level = LVL_FULL;
    end else if (!highSectorWriteGuardOpt) begin
      level = LVL_GUARD;
    end else begin
      level = LVL_OPEN;
    end
  end

  // open level skips sector and page checks; reserved writes only from reserved code
  always_comb begin
    progOk = 1'b0;
    if (inUser(progAddr)) begin
      progOk = (level == LVL_OPEN)
               || ((level == LVL_GUARD) && !q.sectProt[progAddr[12:SECTOR_LSB]]
                   && (pageOf(progAddr) == q.pageSel));
    end else if (inReserved(progAddr)) begin
      progOk = inReserved(fetchAddr) && (level != LVL_FULL);
    end
  end

  // page erase of the selected page; sector check dropped at open level
  always_comb begin
    eraseOk = 1'b0;
    if (q.pageSel < pageOf(USER_TOP)) begin
      eraseOk = (level == LVL_OPEN)
                || ((level == LVL_GUARD)
                    && !q.sectProt[q.pageSel[3:SECTOR_LSB-PAGE_LSB]]);
    end
  end

  // ****************************************************************
  // state update
  // ****************************************************************
  always_comb begin
    d               = q;
    d.cmd.prog      = 1'b0;
    d.cmd.pageErase = 1'b0;
    d.cmd.massErase = 1'b0;
    d.start         = 1'b0;
    d.entry         = callValid && !inReserved(fetchAddr)
                      && inReserved(callTarget);

    if (freqHighWr) begin
      d.freq[15:8] = wrData;
    end
    if (freqLowWr) begin
      d.freq[7:0] = wrData;
    end
    if (sectProtWr) begin
      // outside the open level protection can only be added
      d.sectProt = (level == LVL_OPEN) ? wrData : (q.sectProt | wrData);
    end

    if (ctrlWr) begin
      case (q.lock)
        LK_LOCKED: begin
          d.lock = (wrData == KEY_FIRST) ? LK_KEY1 : LK_LOCKED;
        end
        LK_KEY1: begin
          d.lock = (wrData == KEY_SECOND) ? LK_KEY2 : LK_LOCKED;
        end
        LK_UNLOCKED: begin
          if (opDone || q.cmd.prog || q.start) begin
            d.lock = LK_UNLOCKED;
          end else if ((wrData == CMD_PAGE_ERASE) && eraseOk && !busy) begin
            d.cmd.pageErase = 1'b1;
            d.cmd.addr      = {q.pageSel[4:0], 9'h000};
            d.start         = 1'b1;
            d.op            = OP_PAGE_ERASE;
          end else if ((wrData == CMD_MASS_ERASE) && (level == LVL_OPEN) && !busy) begin
            d.cmd.massErase = 1'b1;
            d.start         = 1'b1;
            d.op            = OP_MASS_ERASE;
          end else begin
            d.lock = LK_LOCKED;
          end
        end
        default: begin
          d.lock = LK_LOCKED;
        end
      endcase
    end else if (pageSelWr) begin
      case (q.lock)
        LK_KEY2: begin
          d.pageSel = wrData;
          d.lock    = (level == LVL_OPEN) ? LK_UNLOCKED : LK_PAGE1;
        end
        LK_PAGE1: begin
          // redundant write must repeat the page, else the unlock is void
          d.lock = (wrData == q.pageSel) ? LK_UNLOCKED : LK_LOCKED;
        end
        LK_UNLOCKED: begin
          if (level == LVL_OPEN) begin
            d.pageSel = wrData;
          end else begin
            d.lock = LK_LOCKED;
          end
        end
        default: begin
          d.lock = LK_LOCKED;
        end
      endcase
    end else if (progReq && (q.lock == LK_UNLOCKED) && !busy && !q.start && progOk) begin
      d.cmd.prog = 1'b1;
      d.cmd.addr = progAddr;
      d.cmd.data = progData;
      d.start    = 1'b1;
      d.op       = OP_PROG;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.lock     <= LK_LOCKED;
      q.freq     <= FREQ_RESET;
      q.pageSel  <= PAGE_SEL_RESET;
      q.sectProt <= SECT_PROT_RESET;
      q.op       <= OP_PROG;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // operation timer
  // ****************************************************************
  fpeg_op_timer #(
    .FREQ_W (FREQ_W)
  ) uTimer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (q.start),
    .op      (q.op),
    .freqKhz (q.freq),
    .busy    (busy),
    .done    (opDone)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign arrayCmd           = q.cmd;
  assign lockState          = q.lock;
  assign protLevel          = level;
  assign flashClockKhzValue = q.freq;
  assign pageSel            = q.pageSel;
  assign sectProt           = q.sectProt;
  assign factoryEntry       = q.entry;
  // user code never reaches the reserved region, reserved code may
  assign accAllow           = accValid && (inUser(accAddr)
                              || (inReserved(accAddr) && inReserved(fetchAddr)));
  assign dbgRdAllow         = !readGuardOpt && inUser(dbgRdAddr);
  // oscillator enable only; clock source selection stays with software
  assign crystalRunInReset  = !crystalOffInReset;
endmodule
`default_nettype wire

// ===== testbench/fpeg_guard_props.sv
// checker for the flash program/erase guard: port relations over time
// assumes it is bound onto fpeg_guard, one clock, active-low async reset
`timescale 1ns/1ps
`default_nettype none
module fpeg_guard_props
  import fpeg_pkg::*;
#(
  parameter int unsigned FREQ_W = 16
) (
  input wire logic                         clk_sys,
  input wire logic                         rstn,
  input wire logic                         writeGuardOpt,
  input wire logic                         highSectorWriteGuardOpt,
  input wire logic                         freqHighWr,
  input wire logic                         ctrlWr,
  input wire logic                         pageSelWr,
  input wire logic                         sectProtWr,
  input wire logic [7:0]                   wrData,
  input wire logic                         progReq,
  input wire logic [13:0]                  fetchAddr,
  input wire logic                         accValid,
  input wire logic [13:0]                  accAddr,
  input wire logic                         callValid,
  input wire logic [13:0]                  callTarget,
  input wire fpeg_pkg::fpeg_array_cmd_type arrayCmd,
  input wire fpeg_pkg::fpeg_lock_type      lockState,
  input wire fpeg_pkg::fpeg_level_type     protLevel,
  input wire logic [FREQ_W-1:0]            flashClockKhzValue,
  input wire logic [7:0]                   pageSel,
  input wire logic [7:0]                   sectProt,
  input wire logic                         accAllow,
  input wire logic                         factoryEntry
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // unlock steps
  // ****************************************************************
  sequence keyPair;
    ctrlWr && wrData == KEY_FIRST ##1 ctrlWr && wrData == KEY_SECOND;
  endsequence
  sequence pageWr;
    pageSelWr && !ctrlWr;
  endsequence

  freq_high_a: assert property (freqHighWr |=> flashClockKhzValue[15:8] == $past(wrData))
    else $error("frequency high byte not taken");
  level_map_a: assert property (protLevel == (!writeGuardOpt ? LVL_FULL :
    (highSectorWriteGuardOpt ? LVL_OPEN : LVL_GUARD))) else $error("wrong protection level");
  guard_unlock_a: assert property ((lockState == LK_LOCKED && protLevel == LVL_GUARD)
    ##0 keyPair ##1 pageWr ##1 pageWr ##0 $stable(wrData) |=> lockState == LK_UNLOCKED)
    else $error("full unlock sequence did not unlock");
  open_unlock_a: assert property ((lockState == LK_LOCKED && protLevel == LVL_OPEN)
    ##0 keyPair ##1 pageWr |=> lockState == LK_UNLOCKED) else $error("open unlock failed");
  guard_relock_a: assert property (lockState == LK_UNLOCKED && protLevel != LVL_OPEN
    && pageWr |=> lockState == LK_LOCKED) else $error("second page opened without unlock");
  open_page_a: assert property (lockState == LK_UNLOCKED && protLevel == LVL_OPEN
    && pageWr |=> lockState == LK_UNLOCKED && pageSel == $past(wrData))
    else $error("page select not writable while unlocked");
  sect_open_a: assert property (sectProtWr && protLevel == LVL_OPEN
    |=> sectProt == $past(wrData)) else $error("sector protect not written");
  sect_keep_a: assert property (sectProtWr && protLevel != LVL_OPEN
    |=> sectProt == ($past(sectProt) | $past(wrData))) else $error("sector protect cleared");
  locked_prog_a: assert property (progReq && lockState != LK_UNLOCKED |=> !arrayCmd.prog)
    else $error("program while locked");
  user_reserved_a: assert property (accValid && fetchAddr < USER_TOP && accAddr >= USER_TOP
    |-> !accAllow) else $error("user code reached reserved region");
  reserved_self_a: assert property (accValid && fetchAddr >= USER_TOP && fetchAddr < SPACE_TOP
    && accAddr >= USER_TOP && accAddr < SPACE_TOP |-> accAllow) else $error("reserved access refused");
  factory_call_a: assert property (callValid && fetchAddr < USER_TOP && callTarget >= USER_TOP
    && callTarget < SPACE_TOP |=> factoryEntry) else $error("factory routines not entered");
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the flash program/erase guard
// assumes fpeg_pkg and fpeg_guard are compiled first; freq kept at 10 kHz, the
// slowest legal clock value, so operations stay short
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
  import fpeg_pkg::*;
  localparam logic [5:0] CTRL = 6'h20, PG = 6'h10, SP = 6'h08, FH = 6'h04, FL = 6'h02, PR = 6'h01;
  logic               clk_sys, rstn, writeGuardOpt, highSectorWriteGuardOpt, readGuardOpt;
  logic               crystalOffInReset, accValid, callValid, busy, accAllow, factoryEntry;
  logic               dbgRdAllow, crystalRunInReset;
  logic [5:0]         stb;
  logic [7:0]         wrData, progData, pageSel, sectProt;
  logic [13:0]        progAddr, fetchAddr, accAddr, callTarget, dbgRdAddr;
  logic [15:0]        flashClockKhzValue;
  fpeg_array_cmd_type arrayCmd;
  fpeg_lock_type      lockState;
  fpeg_level_type     protLevel;
  int                 compares, miscompares, cycles;

  fpeg_guard u_fpeg_guard (.clk_sys, .rstn, .writeGuardOpt, .highSectorWriteGuardOpt,
    .readGuardOpt, .crystalOffInReset, .freqHighWr(stb[2]), .freqLowWr(stb[1]),
    .ctrlWr(stb[5]), .pageSelWr(stb[4]), .sectProtWr(stb[3]), .wrData, .progReq(stb[0]),
    .progAddr, .progData, .fetchAddr, .accValid, .accAddr, .callValid, .callTarget,
    .dbgRdAddr, .arrayCmd, .busy, .lockState, .protLevel, .flashClockKhzValue, .pageSel,
    .sectProt, .accAllow, .factoryEntry, .dbgRdAllow, .crystalRunInReset);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // drivers
  // ****************************************************************
  // strobe stays up until the next call or idle, so no edge sees two writes to stb
  task automatic wr(input logic [5:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    stb    <= s;
    wrData <= d;
  endtask
  task automatic idle;
    @(posedge clk_sys);
    stb <= '0;
    #1;
  endtask
  // counts the cycles busy stands, starting one edge after the start pulse
  task automatic wait_idle(input int unsigned exp);
    int unsigned n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (busy === 1'b1 && n < 2500) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("busy", 1'b0, busy)
    `CHK("cycles", exp, n)
  endtask
  task automatic do_rst(input logic w, input logic h);
    @(posedge clk_sys);
    rstn                    <= 1'b0;
    writeGuardOpt           <= w;
    highSectorWriteGuardOpt <= h;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    wr(FH, 8'h00);
    wr(FL, 8'h0A);
    idle;
  endtask
  task automatic unlock(input logic [7:0] p, input logic twice);
    wr(CTRL, KEY_FIRST);
    wr(CTRL, KEY_SECOND);
    wr(PG, p);
    if (twice) wr(PG, p);
    idle;
  endtask
  task automatic prog(input logic [13:0] a, input logic [7:0] d, input logic ok);
    @(posedge clk_sys);
    stb      <= PR;
    progAddr <= a;
    progData <= d;
    @(posedge clk_sys);
    stb <= '0;
    #1;
    `CHK("prog", ok, arrayCmd.prog)
    if (ok) begin
      `CHK("addr", a, arrayCmd.addr)
      `CHK("data", d, arrayCmd.data)
      wait_idle(1);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_freq;
    wr(FH, 8'h12);
    wr(FL, 8'h34);
    idle;
    `CHK("freq", 16'h1234, flashClockKhzValue)
    wr(FL, 8'h0A);
    wr(FH, 8'h00);
    idle;
    `CHK("freq", 16'h000A, flashClockKhzValue)
  endtask
  task automatic t_guard;
    prog(14'h0410, 8'hA5, 1'b0);
    unlock(8'h02, 1'b1);
    `CHK("lock", LK_UNLOCKED, lockState)
    prog(14'h0410, 8'hA5, 1'b1);
    prog(14'h0610, 8'h5A, 1'b0);
    prog(14'h2010, 8'h3C, 1'b0);
    @(posedge clk_sys) fetchAddr <= 14'h2400;
    prog(14'h2010, 8'h3C, 1'b1);
    @(posedge clk_sys) fetchAddr <= 14'h0000;
    wr(PG, 8'h03);
    idle;
    `CHK("lock", LK_LOCKED, lockState)
    wr(SP, 8'h02);
    wr(SP, 8'h00);
    idle;
    `CHK("sect", 8'h02, sectProt)
    unlock(8'h02, 1'b1);
    prog(14'h0410, 8'hA5, 1'b0);
    wr(CTRL, CMD_MASS_ERASE);
    idle;
    `CHK("merase", 1'b0, arrayCmd.massErase)
    `CHK("lock", LK_LOCKED, lockState)
  endtask
  task automatic t_region;
    @(posedge clk_sys);
    accValid   <= 1'b1;
    accAddr    <= 14'h2100;
    callValid  <= 1'b1;
    callTarget <= 14'h2800;
    #1;
    `CHK("acc", 1'b0, accAllow)
    @(posedge clk_sys);
    callValid <= 1'b0;
    fetchAddr <= 14'h2400;
    #1;
    `CHK("entry", 1'b1, factoryEntry)
    `CHK("acc", 1'b1, accAllow)
    @(posedge clk_sys) accAddr <= 14'h0100;
    #1;
    `CHK("acc", 1'b1, accAllow)
    `CHK("entry", 1'b0, factoryEntry)
    @(posedge clk_sys) fetchAddr <= 14'h0000;
  endtask
  task automatic t_levels;
    for (int i = 0; i < 3; i++) begin
      do_rst(i != 0, i == 2);
      @(posedge clk_sys);
      readGuardOpt      <= i[0];
      crystalOffInReset <= i[0];
      dbgRdAddr         <= 14'h1000;
      #1;
      `CHK("level", fpeg_level_type'(i), protLevel)
      `CHK("xtal", !i[0], crystalRunInReset)
      `CHK("dbg", !i[0], dbgRdAllow)
      if (i == 0) begin
        unlock(8'h02, 1'b1);
        prog(14'h0410, 8'hA5, 1'b0);
      end
    end
  endtask
  task automatic t_open;
    unlock(8'h02, 1'b0);
    `CHK("lock", LK_UNLOCKED, lockState)
    wr(SP, 8'hFF);
    idle;
    prog(14'h0610, 8'h5A, 1'b1);
    wr(SP, 8'h00);
    idle;
    `CHK("sect", 8'h00, sectProt)
    wr(PG, 8'h05);
    idle;
    `CHK("lock", LK_UNLOCKED, lockState)
    `CHK("page", 8'h05, pageSel)
    wr(CTRL, CMD_PAGE_ERASE);
    idle;
    `CHK("perase", 1'b1, arrayCmd.pageErase)
    `CHK("eaddr", 14'h0A00, arrayCmd.addr)
    wait_idle(10 * PAGE_ERASE_US / US_PER_MS);
    wr(CTRL, CMD_MASS_ERASE);
    idle;
    `CHK("merase", 1'b1, arrayCmd.massErase)
    wait_idle(10 * MASS_ERASE_US / US_PER_MS);
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard: whole run needs about 2250 cycles, mostly the mass erase
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      finish_test;
    end
  end

  initial begin
    {rstn, writeGuardOpt, highSectorWriteGuardOpt, readGuardOpt, crystalOffInReset} = '0;
    {stb, wrData, progData, progAddr, fetchAddr} = '0;
    {accValid, accAddr, callValid, callTarget, dbgRdAddr} = '0;
    {compares, miscompares, cycles} = '0;
    do_rst(1'b1, 1'b0);
    t_freq;
    t_guard;
    t_region;
    t_levels;
    do_rst(1'b1, 1'b1);
    t_open;
    finish_test;
  end
endmodule
bind fpeg_guard fpeg_guard_props #(.FREQ_W(FREQ_W)) u_fpeg_guard_props (.clk_sys, .rstn,
  .writeGuardOpt, .highSectorWriteGuardOpt, .freqHighWr, .ctrlWr, .pageSelWr, .sectProtWr,
  .wrData, .progReq, .fetchAddr, .accValid, .accAddr, .callValid, .callTarget, .arrayCmd,
  .lockState, .protLevel, .flashClockKhzValue, .pageSel, .sectProt, .accAllow, .factoryEntry);
`default_nettype wire
